// File: core/sfm_framer.sv
// Purpose: packs frame pairs into fixed multiframes and sends them as a serial bit stream
// Assumes: quantizer on ref_clk, channel takes one bit per ser_strobe
// Notes:   bit rate is made exact on average by a fractional accumulator
//
// Contract
// - multiframe is 168 octets: sync, header, then frame-pair stream
// - one multiframe per 240 ms, channel at 5600 bit/s
// - each frame is 10 ms, so one pair spans 20 ms
// - octets ascending, bit 1 of each octet sent first
// - fields map LSB to lowest bit position, spanning octets LSB first
// - check fields put highest polynomial term at lowest bit position; the header check bits go lowest term at lowest bit position
// - multiframe starts with sync word 0x87B2, octets 10000111 then 10110010
// - inverted sync words may fill the channel between multiframes
// - header protected by (31,16) cyclic code plus even overall parity
// - header octet 1 holds rate, variant, counter, extended flag; then spare, parity
// - header codes for rate, variant and extended; spare bits sent zero
// - sequence counter starts at 0001 and counts modulo 16
// - unused trailing pair slots of final multiframe are all zero
// - pair opens with two 44-bit codebook sections and a 4-bit check
// - then 7-bit absolute pitch and 5-bit differential pitch
// - then two class bits and a 2-bit check over 14 bits
// - twelve 108-bit pairs packed back to back into 1296 bits
// - seven indices per frame, widths 6, 5 and 8 bits
`timescale 1ns/1ps
`default_nettype none
module sfm_framer
    import sfm_pkg::*;
#(
    parameter int CLK_RATE  = CLK_HZ,
    parameter int LINE_RATE = BIT_RATE
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic       inverse_fill,
    input  wire logic [1:0] sample_rate_code,
    input  wire logic       frontend_variant_flag,
    input  wire logic       extended_flag,
    input  wire logic       pair_valid,
    output logic            pair_ready,
    input  wire logic       pair_last,
    input  wire logic [5:0] a_idx01,
    input  wire logic [5:0] a_idx23,
    input  wire logic [5:0] a_idx45,
    input  wire logic [5:0] a_idx67,
    input  wire logic [5:0] a_idx89,
    input  wire logic [4:0] a_idx1011,
    input  wire logic [7:0] a_idx1213,
    input  wire logic       a_voice_activity_flag,
    input  wire logic [5:0] b_idx01,
    input  wire logic [5:0] b_idx23,
    input  wire logic [5:0] b_idx45,
    input  wire logic [5:0] b_idx67,
    input  wire logic [5:0] b_idx89,
    input  wire logic [4:0] b_idx1011,
    input  wire logic [7:0] b_idx1213,
    input  wire logic       b_voice_activity_flag,
    input  wire logic [6:0] a_pitch_abs,
    input  wire logic [4:0] b_pitch_diff,
    input  wire logic       a_class,
    input  wire logic       b_class,
    output logic            ser_data,
    output logic            ser_strobe,
    output logic            mf_start,
    output logic            underrun,
    output logic            busy
);
    // ****************************************
    // check-code helpers
    // ****************************************
    function automatic logic [3:0] crc4(input logic [87:0] s);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 88; i++) begin
            r = {r[2:0], 1'b0} ^ ((s[i] ^ r[3]) ? CRC4_GEN : 4'h0);
        end
        return r;
    endfunction : crc4

    function automatic logic [1:0] crc2(input logic [13:0] s);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < 14; i++) begin
            r = {r[0], 1'b0} ^ ((s[i] ^ r[1]) ? CRC2_GEN : 2'h0);
        end
        return r;
    endfunction : crc2

    function automatic logic [31:0] header(input logic [15:0] d);
        logic [14:0] r;
        r = 15'h0000;
        for (int i = 15; i >= 0; i--) begin
            r = {r[13:0], 1'b0} ^ ((d[i] ^ r[14]) ? HDR_GEN : 15'h0000);
        end
        return {^{d, r}, r, d};
    endfunction : header

    // ****************************************
    // packet assembly
    // ****************************************
    wire logic [43:0] sec_a;
    wire logic [43:0] sec_b;
    wire logic [13:0] pc_bits;
    wire logic [3:0]  cb_chk;
    wire logic [1:0]  pc_chk;
    wire logic [107:0] pkt_in;

    assign sec_a = {a_idx1213, a_idx1011, a_idx89, a_idx67,
                    a_voice_activity_flag, a_idx45, a_idx23, a_idx01};
    assign sec_b = {b_idx1213, b_idx1011, b_idx89, b_idx67,
                    b_voice_activity_flag, b_idx45, b_idx23, b_idx01};
    assign pc_bits = {b_class, a_class, b_pitch_diff, a_pitch_abs};
    assign cb_chk  = crc4({sec_b, sec_a});
    assign pc_chk  = crc2(pc_bits);
    // high term first on the line
    assign pkt_in  = {pc_chk[0], pc_chk[1], pc_bits,
                      cb_chk[0], cb_chk[1], cb_chk[2], cb_chk[3],
                      sec_b, sec_a};

    // ****************************************
    // two-entry pair buffer
    // ****************************************
    logic [108:0] fifo_mem [0:1];
    logic         wr_ptr;
    logic         rd_ptr;
    logic [1:0]   fifo_cnt;
    wire logic    fifo_valid;
    wire logic    push;
    wire logic    pop;
    wire logic [108:0] fifo_head;

    assign pair_ready = (fifo_cnt != 2'h2);
    assign fifo_valid = (fifo_cnt != 2'h0);
    assign push       = pair_valid && pair_ready;
    assign fifo_head  = fifo_mem[rd_ptr];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
        end else if (push) begin
            fifo_mem[wr_ptr] <= {pair_last, pkt_in};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr   <= 1'b0;
            rd_ptr   <= 1'b0;
            fifo_cnt <= 2'h0;
        end else begin
            wr_ptr   <= wr_ptr ^ push;
            rd_ptr   <= rd_ptr ^ pop;
            fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // ****************************************
    // bit timing
    // ****************************************
    // fractional step keeps the average rate exact despite a non-integer period
    localparam logic [24:0] ACC_STEP = 25'(LINE_RATE);
    localparam logic [24:0] ACC_MOD  = 25'(CLK_RATE);
    logic [24:0] acc;
    wire logic [24:0] acc_sum;
    wire logic tick;

    assign acc_sum = acc + ACC_STEP;
    assign tick    = (acc_sum >= ACC_MOD);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc <= 25'h0;
        end else begin
            acc <= tick ? acc_sum - ACC_MOD : acc_sum;
        end
    end

    // ****************************************
    // serializer
    // ****************************************
    sfm_state_e   state;
    sfm_state_e   next_state;
    logic [107:0] shreg;
    logic [6:0]   bits_left;
    logic [3:0]   slot;
    logic [3:0]   seq;
    logic         closing;
    logic         next_load;
    logic [107:0] next_word;
    logic [6:0]   next_len;
    logic         next_pop;
    logic         next_under;
    logic         next_emit;
    wire logic    at_word_end;
    wire logic    last_slot;
    wire logic [15:0] hdr_data;
    wire logic [107:0] pair_word;

    assign at_word_end = (bits_left == 7'h00);
    assign last_slot   = (slot == LAST_SLOT);
    assign hdr_data    = {SPARE_VALUE, extended_flag, seq,
                          frontend_variant_flag, sample_rate_code};
    // zeros after the last pair mark the final multiframe
    assign pair_word   = (!closing && fifo_valid) ? fifo_head[107:0] : '0;
    assign pop         = tick && next_pop;

    always_comb begin
        next_state = state;
        next_load  = 1'b0;
        next_word  = '0;
        next_len   = 7'h00;
        next_pop   = 1'b0;
        next_under = 1'b0;
        next_emit  = 1'b1;
        if (at_word_end) begin
            next_load = 1'b1;
            unique case (state)
                SFM_IDLE, SFM_FILL: begin
                    if (!enable) begin
                        next_state = SFM_IDLE;
                        next_load  = 1'b0;
                        next_emit  = 1'b0;
                    end else if (fifo_valid) begin
                        next_state = SFM_SYNC;
                        next_word  = {92'h0, SYNC_STREAM};
                        next_len   = LEN_SYNC;
                    end else if (inverse_fill) begin
                        next_state = SFM_FILL;
                        next_word  = {92'h0, INV_STREAM};
                        next_len   = LEN_SYNC;
                    end else begin
                        next_state = SFM_IDLE;
                        next_load  = 1'b0;
                        next_emit  = 1'b0;
                    end
                end
                SFM_SYNC: begin
                    next_state = SFM_HDR;
                    next_word  = {76'h0, header(hdr_data)};
                    next_len   = LEN_HDR;
                end
                SFM_HDR, SFM_PKT: begin
                    if (state == SFM_PKT && last_slot) begin
                        // multiframe done; resync back to back unless closing
                        if (!closing) begin
                            next_state = SFM_SYNC;
                            next_word  = {92'h0, SYNC_STREAM};
                            next_len   = LEN_SYNC;
                        end else if (enable && inverse_fill) begin
                            next_state = SFM_FILL;
                            next_word  = {92'h0, INV_STREAM};
                            next_len   = LEN_SYNC;
                        end else begin
                            next_state = SFM_IDLE;
                            next_load  = 1'b0;
                            next_emit  = 1'b0;
                        end
                    end else begin
                        next_state = SFM_PKT;
                        next_word  = pair_word;
                        next_len   = LEN_PAIR;
                        next_pop   = !closing && fifo_valid;
                        next_under = !closing && !fifo_valid;
                    end
                end
                default: begin
                    next_state = SFM_IDLE;
                    next_load  = 1'b0;
                    next_emit  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state     <= SFM_IDLE;
            shreg     <= '0;
            bits_left <= 7'h00;
        end else if (tick) begin
            state     <= next_state;
            shreg     <= next_load ? (next_word >> 1) : (shreg >> 1);
            bits_left <= next_load ? next_len : (at_word_end ? 7'h00 : bits_left - 7'h01);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slot    <= 4'h0;
            seq     <= 4'h0;
            closing <= 1'b0;
        end else if (tick && next_load) begin
            if (next_state == SFM_SYNC) begin
                // counter restarts with every new session
                seq <= (state == SFM_PKT) ? seq + 4'h1 : SEQ_FIRST;
            end
            slot    <= (state == SFM_PKT) ? slot + 4'h1 : 4'h0;
            if (next_state != SFM_PKT) begin
                closing <= 1'b0;
            end else if (next_pop && fifo_head[108]) begin
                closing <= 1'b1;
            end
        end
    end

    // ****************************************
    // line outputs
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ser_data   <= 1'b0;
            ser_strobe <= 1'b0;
            mf_start   <= 1'b0;
            underrun   <= 1'b0;
        end else begin
            ser_data   <= tick ? (next_load ? next_word[0] : shreg[0]) : ser_data;
            ser_strobe <= tick && next_emit;
            mf_start   <= tick && next_load && (next_state == SFM_SYNC);
            underrun   <= tick && next_under;
        end
    end

    assign busy = (state != SFM_IDLE);

endmodule : sfm_framer
`default_nettype wire

// File: core/sfm_pkg.sv
// Purpose: shared constants for the speech feature multiframe framer
// Assumes: one 20 MHz clock
// Notes:   stream words are sent bit 0 first
package sfm_pkg;
    // ****************************************
    // multiframe geometry
    // ****************************************
    localparam int SYNC_BITS   = 16;
    localparam int HDR_BITS    = 32;
    localparam int PAIR_BITS   = 108;
    localparam int FRAME_BITS  = 44;
    localparam int PC_BITS     = 14;
    localparam int MF_PAIRS    = 12;
    localparam int MF_OCTETS   = 168;
    localparam int FEAT_OCTETS = 162;
    localparam int FEAT_BITS   = MF_PAIRS * PAIR_BITS;
    localparam int MF_BITS     = SYNC_BITS + HDR_BITS + FEAT_BITS;
    // ****************************************
    // timing
    // ****************************************
    localparam int FRAME_MS    = 10;
    localparam int PAIR_MS     = 2 * FRAME_MS;
    localparam int MF_MS       = MF_PAIRS * PAIR_MS;
    localparam int BIT_RATE    = MF_BITS * 1000 / MF_MS;
    localparam int CLK_HZ      = 20_000_000;
    // ****************************************
    // codes; SYNC_STREAM and INV_STREAM as sent bit 0 first
    // ****************************************
    localparam logic [15:0] SYNC_WORD    = 16'h87B2;
    localparam logic [15:0] INV_SYNC     = 16'h784D;
    localparam logic [15:0] SYNC_STREAM  = {SYNC_WORD[7:0], SYNC_WORD[15:8]};
    localparam logic [15:0] INV_STREAM   = {INV_SYNC[7:0], INV_SYNC[15:8]};
    localparam logic [14:0] HDR_GEN      = 15'h5101;
    localparam logic [3:0]  CRC4_GEN     = 4'h3;
    localparam logic [1:0]  CRC2_GEN     = 2'h3;
    localparam logic [3:0]  SEQ_FIRST    = 4'h1;
    localparam logic [7:0]  SPARE_VALUE  = 8'h00;
    localparam logic [3:0]  LAST_SLOT    = 4'hB;
    localparam logic [6:0]  LEN_SYNC     = 7'h0F;
    localparam logic [6:0]  LEN_HDR      = 7'h1F;
    localparam logic [6:0]  LEN_PAIR     = 7'h6B;
    // ****************************************
    // serializer states
    // ****************************************
    typedef enum logic [2:0] {
        SFM_IDLE = 3'b000,
        SFM_FILL = 3'b001,
        SFM_SYNC = 3'b010,
        SFM_HDR  = 3'b011,
        SFM_PKT  = 3'b100
    } sfm_state_e;
endpackage : sfm_pkg

// File: verification/sfm_framer_chk.sv
// Purpose: concurrent checks on the framer line side
// Assumes: header code inputs stay steady while a header goes out
// Notes:   bidx of 7FF means no multiframe since reset, or 2047 bits or more since the last multiframe start
`timescale 1ns/1ps
`default_nettype none
module sfm_framer_chk
    import sfm_pkg::*;
#(
    parameter int CLK_RATE  = CLK_HZ,
    parameter int LINE_RATE = BIT_RATE
) (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [1:0] sample_rate_code,
    input wire logic       frontend_variant_flag,
    input wire logic       extended_flag,
    input wire logic       ser_data,
    input wire logic       ser_strobe,
    input wire logic       mf_start
);
    localparam int          GAP       = CLK_RATE / LINE_RATE;
    localparam logic [15:0] SYNC_LINE = 16'hB287;
    logic [10:0] bidx;
    logic [10:0] idx_now;
    logic [31:0] gcnt;
    assign idx_now = mf_start ? 11'h000 : bidx;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bidx <= 11'h7FF;
            gcnt <= 32'h0;
        end else begin
            gcnt <= ser_strobe ? 32'h1 : gcnt + 32'h1;
            if (mf_start) begin
                bidx <= 11'h001;
            end else if (ser_strobe && bidx != 11'h7FF) begin
                bidx <= bidx + 11'h001;
            end
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_open;
        ser_strobe && ser_data;
    endsequence
    property p_open;
        mf_start |-> s_open;
    endproperty
    a_open: assert property (p_open) else $error("multiframe not opened by a strobed one");
    property p_sync;
        ser_strobe && idx_now < 11'h010 |-> ser_data == SYNC_LINE[idx_now[3:0]];
    endproperty
    a_sync: assert property (p_sync) else $error("sync bit wrong");
    property p_rate;
        ser_strobe && idx_now[10:1] == 10'h008 |-> ser_data == sample_rate_code[idx_now[0]];
    endproperty
    a_rate: assert property (p_rate) else $error("rate code bit wrong");
    property p_variant;
        ser_strobe && idx_now == 11'h012 |-> ser_data == frontend_variant_flag;
    endproperty
    a_variant: assert property (p_variant) else $error("variant bit wrong");
    property p_ext;
        ser_strobe && idx_now == 11'h017 |-> ser_data == extended_flag;
    endproperty
    a_ext: assert property (p_ext) else $error("extended bit wrong");
    property p_spare;
        ser_strobe && idx_now[10:3] == 8'h03 |-> !ser_data;
    endproperty
    a_spare: assert property (p_spare) else $error("spare bit not zero");
    property p_gap;
        ser_strobe && !mf_start && bidx < 11'h540 |-> gcnt >= GAP && gcnt <= GAP + 1;
    endproperty
    a_gap: assert property (p_gap) else $error("bit spacing off rate");
    property p_len;
        mf_start |-> bidx >= 11'h540;
    endproperty
    a_len: assert property (p_len) else $error("multiframe cut short");
endmodule : sfm_framer_chk
bind sfm_framer sfm_framer_chk #(.CLK_RATE(CLK_RATE), .LINE_RATE(LINE_RATE)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .sample_rate_code(sample_rate_code),
    .frontend_variant_flag(frontend_variant_flag), .extended_flag(extended_flag),
    .ser_data(ser_data), .ser_strobe(ser_strobe), .mf_start(mf_start));
`default_nettype wire

// File: verification/sfm_rx_model.sv
// Purpose: remote receiver that records every line bit the framer sends
// Assumes: ser_data is valid in the cycle of ser_strobe
// Notes:   the bench reads rx and mfs by hierarchy; this end has nothing to answer
`timescale 1ns/1ps
`default_nettype none
module sfm_rx_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ser_data,
    input wire logic ser_strobe,
    input wire logic mf_start
);
    logic rx[$];
    int   mfs[$];
    always @(posedge ref_clk) begin
        if (!rst && ser_strobe === 1'b1) begin
            if (mf_start === 1'b1) mfs.push_back(rx.size());
            rx.push_back(ser_data);
        end
    end
endmodule : sfm_rx_model
`default_nettype wire

// File: verification/test_sfm_framer.sv
// Purpose: self-checking bench for the multiframe framer
// Assumes: line sped up to 10 Mbit/s, two clocks a bit
// Notes:   expected streams are rebuilt from the stimulus alone
`timescale 1ns/1ps
`default_nettype none
module test_sfm_framer;
    import sfm_pkg::*;
    logic         ref_clk, rst, enable, inverse_fill, pair_valid, pair_last;
    logic         frontend_variant_flag, extended_flag;
    logic [1:0]   sample_rate_code;
    logic [101:0] pv;
    logic         pair_ready, ser_data, ser_strobe, mf_start, underrun, busy;
    logic [107:0] slots[$];
    int           n_fail = 0, n_tests = 0, n_stall = 0, n_under = 0, u0, base, len, bad;
    sfm_framer #(.LINE_RATE(10_000_000)) u_dut (
        .ref_clk, .rst, .enable, .inverse_fill, .sample_rate_code, .frontend_variant_flag, .extended_flag,
        .pair_valid, .pair_ready, .pair_last, .ser_data, .ser_strobe, .mf_start, .underrun, .busy,
        // pv holds the packet fields in sent order
        .a_idx01(pv[5:0]), .a_idx23(pv[11:6]), .a_idx45(pv[17:12]), .a_voice_activity_flag(pv[18]),
        .a_idx67(pv[24:19]), .a_idx89(pv[30:25]), .a_idx1011(pv[35:31]), .a_idx1213(pv[43:36]),
        .b_idx01(pv[49:44]), .b_idx23(pv[55:50]), .b_idx45(pv[61:56]), .b_voice_activity_flag(pv[62]),
        .b_idx67(pv[68:63]), .b_idx89(pv[74:69]), .b_idx1011(pv[79:75]), .b_idx1213(pv[87:80]),
        .a_pitch_abs(pv[94:88]), .b_pitch_diff(pv[99:95]), .a_class(pv[100]), .b_class(pv[101]));
    sfm_rx_model u_rx (.ref_clk, .rst, .ser_data, .ser_strobe, .mf_start);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (underrun === 1'b1) n_under++;
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    // line order, bit 0 first; checks go out highest term first
    function automatic logic [107:0] pkt(input logic [101:0] v);
        logic [3:0] c4;
        logic [1:0] c2;
        c4 = '0;
        c2 = '0;
        for (int i = 0; i < 88; i++) c4 = {c4[2:0], 1'b0} ^ ((v[i] ^ c4[3]) ? 4'h3 : 4'h0);
        for (int i = 88; i < 102; i++) c2 = {c2[0], 1'b0} ^ ((v[i] ^ c2[1]) ? 2'h3 : 2'h0);
        return {c2[0], c2[1], v[101:88], c4[0], c4[1], c4[2], c4[3], v[87:0]};
    endfunction : pkt
    function automatic logic [31:0] hdr(input logic [3:0] seq);
        logic [15:0] d;
        logic [14:0] r;
        d = {8'h00, extended_flag, seq, frontend_variant_flag, sample_rate_code};
        r = '0;
        for (int i = 15; i >= 0; i--) r = {r[13:0], 1'b0} ^ ((d[i] ^ r[14]) ? 15'h5101 : 15'h0000);
        return {^{d, r}, r, d};
    endfunction : hdr
    task automatic chk_mf(input int j, input logic [3:0] seq, input int s0);
        logic [1343:0] e;
        int            m;
        e = '0;
        m = -1;
        e[15:0] = 16'hB287;
        e[47:16] = hdr(seq);
        for (int k = 0; k < 12; k++) if (s0 + k < slots.size()) e[48 + 108 * k +: 108] = slots[s0 + k];
        for (int i = 0; i < 1344; i++) if (m < 0 && u_rx.rx[u_rx.mfs[j] + i] !== e[i]) m = i;
        check(m < 0, $sformatf("multiframe %0d differs at bit %0d", j, m));
    endtask : chk_mf
    task automatic offer(input int k, input logic last);
        @(negedge ref_clk);
        pv = {6{17'(k * 17'h1B3C5 + 17'h0A5E1)}};
        pair_last = last;
        pair_valid = 1'b1;
        slots.push_back(pkt(pv));
        if (pair_ready !== 1'b1) n_stall++;
        for (int t = 0; t < 9000 && pair_ready !== 1'b1; t++) @(negedge ref_clk);
        check(pair_ready === 1'b1, "pair never accepted");
        @(posedge ref_clk);
    endtask : offer
    task automatic release_pair();
        @(negedge ref_clk);
        pair_valid = 1'b0;
        pair_last = 1'b0;
        pv = ~pv;
    endtask : release_pair
    task automatic wait_mfs(input int n);
        for (int t = 0; t < 60000 && u_rx.mfs.size() < n; t++) @(negedge ref_clk);
        check(u_rx.mfs.size() >= n, "multiframe start not seen");
    endtask : wait_mfs
    task automatic wait_idle();
        for (int t = 0; t < 60000 && busy !== 1'b0; t++) @(negedge ref_clk);
        check(busy === 1'b0, "framer never went idle");
    endtask : wait_idle
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    initial begin
        {rst, enable, inverse_fill, pair_valid, pair_last} = 5'b10100;
        {sample_rate_code, frontend_variant_flag, extended_flag} = 4'hF;
        pv = '0;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        enable = 1'b1;
        for (int k = 1; k <= 205; k++) offer(k, k == 205);
        release_pair();
        wait_mfs(18);
        for (int t = 0; t < 9000 && u_rx.rx.size() < u_rx.mfs[17] + 1392; t++) @(negedge ref_clk);
        check(n_stall > 0, "source never held off");
        check(n_under == 0, "slot zero-filled while data waited");
        bad = 0;
        for (int j = 1; j < 18; j++) if (u_rx.mfs[j] != u_rx.mfs[j - 1] + 1344) bad++;
        check(bad == 0, "multiframes not back to back");
        for (int j = 0; j < 18; j++) chk_mf(j, 4'(j + 1), 12 * j);
        $display("test long session done");
        {sample_rate_code, frontend_variant_flag, extended_flag} = 4'h4;
        slots.delete();
        u0 = n_under;
        offer(500, 1'b0);
        release_pair();
        wait_mfs(19);
        inverse_fill = 1'b0;
        for (int t = 0; t < 9000 && n_under == u0; t++) @(negedge ref_clk);
        slots.push_back('0);
        offer(501, 1'b1);
        release_pair();
        wait_idle();
        base = u_rx.mfs[17] + 1344;
        len = u_rx.mfs[18] - base;
        check(len > 0 && len % 16 == 0, "fill not whole words");
        bad = 0;
        for (int i = 0; i < len; i++) if (u_rx.rx[base + i] !== ((16'h4D78 >> (i % 16)) & 16'h1)) bad++;
        check(bad == 0, "fill word pattern");
        check(n_under - u0 == 1, "zero-filled slot count");
        chk_mf(18, 4'h1, 0);
        len = u_rx.rx.size();
        repeat (100) @(negedge ref_clk);
        check(u_rx.rx.size() == len, "line active while idle");
        $display("test underrun and fill done");
        for (int r = 0; r < 2; r++) begin
            {sample_rate_code, frontend_variant_flag, extended_flag} = r ? 4'hA : 4'h1;
            slots.delete();
            offer(600 + r, 1'b1);
            release_pair();
            wait_mfs(20 + r);
            wait_idle();
            chk_mf(19 + r, 4'h1, 0);
        end
        // fill requested but framer disabled: the line must stay quiet
        inverse_fill = 1'b1;
        enable = 1'b0;
        len = u_rx.rx.size();
        repeat (100) @(negedge ref_clk);
        check(u_rx.rx.size() == len && busy === 1'b0, "fill sent while disabled");
        $display("test header codes done");
        results();
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        $display("mismatch at %0t: run did not finish", $time);
        results();
    end
endmodule : test_sfm_framer
`default_nettype wire
